// file: rtl/idetf_defs.vh
// Register offsets, field positions, reset values and IDE addressing codes for the task file bank.
`ifndef IDETF_DEFS_VH
`define IDETF_DEFS_VH
`define IDETF_OFF_COMMAND 8'h44
`define IDETF_OFF_CYL_LOW 8'h4b
`define IDETF_OFF_CYL_HIGH 8'h4c
`define IDETF_OFF_DRIVE_HEAD 8'h4d
`define IDETF_OFF_ALT_STATUS 8'h4e
`define IDETF_OFF_DRIVE_ADDR 8'h4f
`define IDETF_OFF_REASON_LO 8'h50
`define IDETF_OFF_REASON_HI 8'h51
`define IDETF_OFF_ENABLE_LO 8'h54
`define IDETF_OFF_ENABLE_HI 8'h55
`define IDETF_TF_RESET 8'h00
`define IDETF_COMMAND_READ 8'hff
`define IDETF_REASON_RESET 16'h0000
`define IDETF_ENABLE_RESET 16'h0000
`define IDETF_REASON_WMASK 16'h1f1e
`define IDETF_ENABLE_WMASK 16'h1f1e
`define IDETF_BIT_CUT_SHORT 15
`define IDETF_BIT_SLAVE_STOP 12
`define IDETF_BIT_EXT_END 11
`define IDETF_BIT_INT_END 10
`define IDETF_BIT_IRQ_SEEN 9
`define IDETF_BIT_COUNT_DONE 8
`define IDETF_BIT_FIFO_UNREAD 4
`define IDETF_BIT_BUSY_CLEAR 3
`define IDETF_BIT_READBACK 2
`define IDETF_BIT_XFER_IRQ 1
`define IDETF_SEL_CS1N_HI_CS0N_LO 2'b10
`define IDETF_SEL_CS1N_LO_CS0N_HI 2'b01
`define IDETF_SEL_IDLE 2'b11
`define IDETF_DA_CYL_LOW 3'b100
`define IDETF_DA_CYL_HIGH 3'b101
`define IDETF_DA_DRIVE_HEAD 3'b110
`define IDETF_DA_COMMAND 3'b111
`define IDETF_DA_ALT_STATUS 3'b110
`define IDETF_DA_DRIVE_ADDR 3'b111
`endif

// file: rtl/idetf_regs.v
// Task file proxy registers and DMA interrupt reason/enable registers of the IDE bridge.
`timescale 1ns/10ps
`include "idetf_defs.vh"
// How it works
// R1 - Cylinder-low proxy at 4Bh drives PIO with CS1_N high, CS0_N low, DA 100.
// R2 - Cylinder-high proxy at 4Ch addresses drive with CS1_N high, CS0_N low, DA 101.
// R3 - Drive/head proxy at 4Dh addresses drive with CS1_N high, CS0_N low, DA 110.
// R4 - Command proxy write at 44h gives PIO write, CS1_N high, CS0_N low, DA 111.
// R5 - Command proxy is write-only; reading it returns FFh.
// R6 - Alternate status proxy at 4Eh uses CS1_N low, CS0_N high, DA 110.
// R7 - Drive-address proxy at 4Fh uses CS1_N low, CS0_N high, DA 111.
// R8 - Interrupt reason register is 16 bits at offset 50h.
// R9 - Reason bits are refreshed when a DMA command finishes.
// R10 - Writing 1 clears a reason bit; writing 0 leaves it.
// R11 - Software masks reason value with enable bits itself.
// R12 - Bit 15 is read-only, set when an OUT packet DMA ends early.
// R13 - Bit 12 sets when the slave DMA stop command is issued.
// R14 - Bit 11 sets on external end-of-transfer, only in slave mode.
// R15 - Bit 10 sets on internal end-of-transfer such as a short packet.
// R16 - Bit 9 sets when the drive interrupt line is pending.
// R17 - Bit 8 sets when the transfer counter hits zero, slave or master mode.
// R18 - Bit 4 sets when the data FIFO holds unread data.
// R19 - Bit 3 sets when drive busy cleared and polling stopped.
// R20 - Bit 2 sets when task file readback command completes.
// R21 - Bit 1 sets only when count is zero and drive interrupt seen.
// R22 - Software writes the command proxy last.
// R23 - Internal end and count done together classify short-packet termination.
// R24 - Enable register at 54h gates each reason bit except bit 15 onto the interrupt.
// R25 - Proxies and reason bits clear on power-on and USB bus reset.
module idetf_regs
(
   // Clock and resets
   input wire clk,
   input wire reset,
   input wire bus_reset,
   // Microcontroller register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Event sources, one-cycle pulses, and DMA mode levels
   input wire dma_cmd_done,
   input wire slave_dma_mode,
   input wire master_dma_mode,
   input wire out_packet_cut_short,
   input wire slave_dma_stopped,
   input wire external_transfer_end,
   input wire internal_transfer_end,
   input wire drive_irq_seen,
   input wire dma_count_done,
   input wire data_fifo_unread,
   input wire drive_busy_cleared,
   input wire regs_readback_done,
   // IDE PIO cycle request
   output reg pio_start,
   output reg pio_write,
   output reg cs1_n,
   output reg cs0_n,
   output reg [2:0] da,
   output reg [7:0] pio_wdata,
   // Interrupt and classification
   output reg dma_irq,
   output reg short_premature,
   output reg short_count_done
);

   reg [7:0] cyl_low_reg;
   reg [7:0] cyl_high_reg;
   reg [7:0] drive_head_reg;
   reg [7:0] alt_status_reg;
   reg [7:0] drive_addr_reg;
   reg [15:0] reason_reg;
   reg [15:0] reason_next;
   reg [15:0] enable_reg;
   reg [15:0] events;
   reg [15:0] clr_mask;
   reg [7:0] rdata_next;
   reg sel_hit;
   reg [1:0] sel_cs;
   reg [2:0] sel_da;
   reg xfer_done_seen;
   // Reserved and status bits of the enable register never take a write.
   wire [15:0] enable_wmask;
   assign enable_wmask = `IDETF_ENABLE_WMASK;

   // Gather hardware events; only counted when a DMA command completes.
   always @*
   begin
      events = 16'h0000;
      events[`IDETF_BIT_CUT_SHORT] = out_packet_cut_short; // R12
      events[`IDETF_BIT_SLAVE_STOP] = slave_dma_stopped; // R13
      events[`IDETF_BIT_EXT_END] = external_transfer_end & slave_dma_mode; // R14
      events[`IDETF_BIT_INT_END] = internal_transfer_end; // R15
      events[`IDETF_BIT_IRQ_SEEN] = drive_irq_seen; // R16
      events[`IDETF_BIT_COUNT_DONE] = dma_count_done & (slave_dma_mode | master_dma_mode); // R17
      events[`IDETF_BIT_FIFO_UNREAD] = data_fifo_unread; // R18
      events[`IDETF_BIT_BUSY_CLEAR] = drive_busy_cleared; // R19
      events[`IDETF_BIT_READBACK] = regs_readback_done; // R20
      // A count that empties together with the command end still counts for bit 1.
      events[`IDETF_BIT_XFER_IRQ] = (xfer_done_seen | dma_count_done) & drive_irq_seen; // R21
   end

   // Write-one-to-clear; a new event in the same cycle wins over the clear.
   always @*
   begin
      clr_mask = 16'h0000;
      if (reg_wr && reg_addr == `IDETF_OFF_REASON_LO)
      begin
         clr_mask[7:0] = reg_wdata; // R10
      end
      else if (reg_wr && reg_addr == `IDETF_OFF_REASON_HI)
      begin
         clr_mask[15:8] = reg_wdata; // R10
      end
      clr_mask = clr_mask & `IDETF_REASON_WMASK; // R12
      reason_next = reason_reg & ~clr_mask;
      if (dma_cmd_done)
      begin
         reason_next = reason_next | events; // R9
      end
   end

   // Address decode for the proxies selects chip selects and drive address lines.
   always @*
   begin
      sel_hit = 1'b1;
      sel_cs = `IDETF_SEL_CS1N_HI_CS0N_LO;
      sel_da = `IDETF_DA_COMMAND;
      if (reg_addr == `IDETF_OFF_CYL_LOW)
      begin
         sel_da = `IDETF_DA_CYL_LOW; // R1
      end
      else if (reg_addr == `IDETF_OFF_CYL_HIGH)
      begin
         sel_da = `IDETF_DA_CYL_HIGH; // R2
      end
      else if (reg_addr == `IDETF_OFF_DRIVE_HEAD)
      begin
         sel_da = `IDETF_DA_DRIVE_HEAD; // R3
      end
      else if (reg_addr == `IDETF_OFF_COMMAND)
      begin
         sel_da = `IDETF_DA_COMMAND; // R4
         // A command read never reaches the drive, so its status is not disturbed.
         sel_hit = reg_wr; // R5
      end
      else if (reg_addr == `IDETF_OFF_ALT_STATUS)
      begin
         sel_cs = `IDETF_SEL_CS1N_LO_CS0N_HI; // R6
         sel_da = `IDETF_DA_ALT_STATUS; // R6
      end
      else if (reg_addr == `IDETF_OFF_DRIVE_ADDR)
      begin
         sel_cs = `IDETF_SEL_CS1N_LO_CS0N_HI; // R7
         sel_da = `IDETF_DA_DRIVE_ADDR; // R7
      end
      else
      begin
         sel_hit = 1'b0;
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always @*
   begin
      rdata_next = 8'h00;
      if (reg_addr == `IDETF_OFF_CYL_LOW)
      begin
         rdata_next = cyl_low_reg;
      end
      else if (reg_addr == `IDETF_OFF_CYL_HIGH)
      begin
         rdata_next = cyl_high_reg;
      end
      else if (reg_addr == `IDETF_OFF_DRIVE_HEAD)
      begin
         rdata_next = drive_head_reg;
      end
      else if (reg_addr == `IDETF_OFF_COMMAND)
      begin
         rdata_next = `IDETF_COMMAND_READ; // R5
      end
      else if (reg_addr == `IDETF_OFF_ALT_STATUS)
      begin
         rdata_next = alt_status_reg;
      end
      else if (reg_addr == `IDETF_OFF_DRIVE_ADDR)
      begin
         rdata_next = drive_addr_reg;
      end
      else if (reg_addr == `IDETF_OFF_REASON_LO)
      begin
         rdata_next = reason_reg[7:0]; // R8
      end
      else if (reg_addr == `IDETF_OFF_REASON_HI)
      begin
         rdata_next = reason_reg[15:8]; // R8
      end
      else if (reg_addr == `IDETF_OFF_ENABLE_LO)
      begin
         rdata_next = enable_reg[7:0];
      end
      else if (reg_addr == `IDETF_OFF_ENABLE_HI)
      begin
         rdata_next = enable_reg[15:8];
      end
   end

   // Bus reset clears the same state as power-on reset, one clock later.
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cyl_low_reg <= `IDETF_TF_RESET; // R25
         cyl_high_reg <= `IDETF_TF_RESET;
         drive_head_reg <= `IDETF_TF_RESET;
         alt_status_reg <= `IDETF_TF_RESET;
         drive_addr_reg <= `IDETF_TF_RESET;
         reason_reg <= `IDETF_REASON_RESET;
         enable_reg <= `IDETF_ENABLE_RESET;
         xfer_done_seen <= 1'b0;
         reg_rdata <= 8'h00;
         pio_start <= 1'b0;
         pio_write <= 1'b0;
         cs1_n <= 1'b1;
         cs0_n <= 1'b1;
         da <= 3'b000;
         pio_wdata <= 8'h00;
         dma_irq <= 1'b0;
         short_premature <= 1'b0;
         short_count_done <= 1'b0;
      end
      else if (bus_reset)
      begin
         // The bus reset leaves the drive idle exactly as power-on reset does.
         cyl_low_reg <= `IDETF_TF_RESET; // R25
         cyl_high_reg <= `IDETF_TF_RESET;
         drive_head_reg <= `IDETF_TF_RESET;
         alt_status_reg <= `IDETF_TF_RESET;
         drive_addr_reg <= `IDETF_TF_RESET;
         reason_reg <= `IDETF_REASON_RESET;
         enable_reg <= `IDETF_ENABLE_RESET;
         xfer_done_seen <= 1'b0;
         reg_rdata <= 8'h00;
         pio_start <= 1'b0;
         pio_write <= 1'b0;
         cs1_n <= 1'b1;
         cs0_n <= 1'b1;
         da <= 3'b000;
         pio_wdata <= 8'h00;
         dma_irq <= 1'b0;
         short_premature <= 1'b0;
         short_count_done <= 1'b0;
      end
      else
      begin
         if (reg_wr)
         begin
            if (reg_addr == `IDETF_OFF_CYL_LOW)
               cyl_low_reg <= reg_wdata;
            if (reg_addr == `IDETF_OFF_CYL_HIGH)
               cyl_high_reg <= reg_wdata;
            if (reg_addr == `IDETF_OFF_DRIVE_HEAD)
               drive_head_reg <= reg_wdata;
            if (reg_addr == `IDETF_OFF_ALT_STATUS)
               alt_status_reg <= reg_wdata;
            if (reg_addr == `IDETF_OFF_DRIVE_ADDR)
               drive_addr_reg <= reg_wdata;
            if (reg_addr == `IDETF_OFF_ENABLE_LO)
               enable_reg[7:0] <= reg_wdata & enable_wmask[7:0]; // R24
            if (reg_addr == `IDETF_OFF_ENABLE_HI)
               enable_reg[15:8] <= reg_wdata & enable_wmask[15:8]; // R24
         end
         // The count-done latch lets the drive interrupt arrive after the count empties.
         if (dma_cmd_done)
            xfer_done_seen <= 1'b0;
         else if (dma_count_done)
            xfer_done_seen <= 1'b1; // R21
         reason_reg <= reason_next;
         // Read data is registered every cycle, so it lags the address by one edge.
         reg_rdata <= rdata_next;
         // Each proxy access except a command read launches one PIO cycle toward the drive.
         pio_start <= sel_hit & (reg_wr | reg_rd);
         pio_write <= sel_hit & reg_wr;
         cs1_n <= sel_hit & (reg_wr | reg_rd) ? sel_cs[1] : 1'b1;
         cs0_n <= sel_hit & (reg_wr | reg_rd) ? sel_cs[0] : 1'b1;
         da <= sel_hit & (reg_wr | reg_rd) ? sel_da : 3'b000;
         pio_wdata <= reg_wdata;
         // The interrupt follows the next reason value, so a clear drops it at once.
         dma_irq <= |(reason_next & enable_reg); // R24
         // The two short-packet classes exclude each other by the state of bit 8.
         short_premature <= reason_next[`IDETF_BIT_INT_END] &
            ~reason_next[`IDETF_BIT_COUNT_DONE]; // R23
         short_count_done <= reason_next[`IDETF_BIT_INT_END] &
            reason_next[`IDETF_BIT_COUNT_DONE]; // R23
      end
   end

endmodule

// file: dv/idetf_drive_model.sv
// Behavioural drive on the IDE bus that records the last PIO cycle it was offered.
`timescale 1ns/10ps
module idetf_drive_model
(
   // Clock
   input wire clk,
   // IDE PIO cycle
   input wire pio_start,
   input wire pio_write,
   input wire cs1_n,
   input wire cs0_n,
   input wire [2:0] da,
   input wire [7:0] pio_wdata,
   // Record of the last cycle
   output reg [13:0] last_cycle
);
   initial last_cycle = 14'h0000;
   // The drive samples select, address and data only while a cycle is offered.
   always @(posedge clk)
      if (pio_start)
         last_cycle <= {pio_write, cs1_n, cs0_n, da, pio_wdata};
endmodule

// file: dv/idetf_regs_checker.sv
// Timing checks on the task file proxy and interrupt reason ports.
`timescale 1ns/10ps
module idetf_regs_checker
(
   // Clock and resets
   input wire clk,
   input wire reset,
   input wire bus_reset,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire dma_cmd_done,
   // PIO cycle and status
   input wire pio_start,
   input wire pio_write,
   input wire cs1_n,
   input wire cs0_n,
   input wire [2:0] da,
   input wire [7:0] pio_wdata,
   input wire dma_irq,
   input wire short_premature,
   input wire short_count_done
);
   wire wr_ok;
   wire acc_ok;
   // A bus reset in the same cycle wins over any request, so it is left out.
   assign wr_ok = reg_wr && !reg_rd && !bus_reset;
   assign acc_ok = (reg_wr ^ reg_rd) && !bus_reset;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_CYL_LOW: assert property (wr_ok && reg_addr == 8'h4b |=> pio_start && pio_write &&
      {cs1_n, cs0_n, da} == 5'h14 && pio_wdata == $past(reg_wdata)) else $error("cyl low");
   AST_CYL_HIGH: assert property (acc_ok && reg_addr == 8'h4c |=> pio_start &&
      {cs1_n, cs0_n, da} == 5'h15) else $error("cyl high addressing");
   AST_DRV_HEAD: assert property (acc_ok && reg_addr == 8'h4d |=> pio_start &&
      {cs1_n, cs0_n, da} == 5'h16) else $error("drive head addressing");
   AST_CMD_WR: assert property (wr_ok && reg_addr == 8'h44 |=> pio_start && pio_write &&
      {cs1_n, cs0_n, da} == 5'h17 && pio_wdata == $past(reg_wdata)) else $error("command");
   AST_CMD_RD: assert property (reg_rd && !reg_wr && reg_addr == 8'h44 && !bus_reset |=>
      reg_rdata == 8'hff && !pio_start) else $error("command read");
   AST_ALT_STAT: assert property (acc_ok && reg_addr == 8'h4e |=> pio_start &&
      {cs1_n, cs0_n, da} == 5'h0e) else $error("alt status addressing");
   AST_DRV_ADDR: assert property (acc_ok && reg_addr == 8'h4f |=> pio_start &&
      {cs1_n, cs0_n, da} == 5'h0f) else $error("drive address addressing");
   AST_BUS_RST: assert property (bus_reset |=> !dma_irq && !pio_start &&
      !short_premature && !short_count_done && cs1_n && cs0_n) else $error("bus reset");
   AST_SHORT: assert property (reg_rd && !reg_wr && reg_addr == 8'h51 && !bus_reset &&
      !dma_cmd_done |=> short_premature == (reg_rdata[2] && !reg_rdata[0]) &&
      short_count_done == (reg_rdata[2] && reg_rdata[0])) else $error("short flags");
   CV_CMD: cover property (wr_ok && reg_addr == 8'h44);
   CV_IRQ: cover property (dma_irq);
   CV_SHORT: cover property (short_premature);
endmodule
bind idetf_regs idetf_regs_checker chk (.*);

// file: dv/ide_taskfile_dma_irq_status_tb_top.sv
// Self-checking bench for the task file proxies and the interrupt reason register.
`timescale 1ns/10ps
module ide_taskfile_dma_irq_status_tb_top;
   localparam [39:0] OFFS = 40'h4b_4c4d_4e4f;
   localparam [39:0] SELS = 40'h14_1516_0e0f;
   reg clk, reset, bus_reset, reg_wr, reg_rd, dma_cmd_done, slave_dma_mode, master_dma_mode;
   reg out_packet_cut_short, slave_dma_stopped, external_transfer_end, internal_transfer_end;
   reg drive_irq_seen, dma_count_done, data_fifo_unread, drive_busy_cleared, regs_readback_done;
   reg [7:0] reg_addr, reg_wdata, got, a, s, d;
   reg [8:0] ev_lv;
   wire [7:0] reg_rdata, pio_wdata;
   wire [2:0] da;
   wire [13:0] last_cycle;
   wire pio_start, pio_write, cs1_n, cs0_n, dma_irq, short_premature, short_count_done;
   integer errors, n_compared, i;
   idetf_regs dut (.*);
   idetf_drive_model drv (.*);
   always @*
      {out_packet_cut_short, slave_dma_stopped, external_transfer_end, internal_transfer_end,
       drive_irq_seen, dma_count_done, data_fifo_unread, drive_busy_cleared,
       regs_readback_done} = ev_lv;
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task chk(input [8*8-1:0] nm, input [15:0] exp, input [15:0] seen);
   begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task wr(input [7:0] ad, input [7:0] dv);
   begin
      reg_addr = ad;
      reg_wdata = dv;
      reg_wr = 1'h1;
      @(posedge clk) #1;
      reg_wr = 1'h0;
      @(posedge clk) #1;
   end
   endtask
   task rd(input [7:0] ad);
   begin
      reg_addr = ad;
      reg_rd = 1'h1;
      @(posedge clk) #1;
      reg_rd = 1'h0;
      got = reg_rdata;
      @(posedge clk) #1;
   end
   endtask
   // The event levels, except dma_count_done, are only looked at while the command end pulse is high.
   task pulse(input [8:0] v, input sm, input mm);
   begin
      ev_lv = v;
      slave_dma_mode = sm;
      master_dma_mode = mm;
      dma_cmd_done = 1'h1;
      @(posedge clk) #1;
      dma_cmd_done = 1'h0;
      ev_lv = 9'h000;
      @(posedge clk) #1;
   end
   endtask
   task t_proxies;
   begin
      for (i = 0; i < 5; i = i + 1)
      begin
         a = OFFS[39 - 8 * i -: 8];
         s = SELS[39 - 8 * i -: 8];
         d = 8'h21 + i;
         rd(a);
         chk("proxy", 16'h0000, got);
         wr(a, d);
         chk("pio", {1'h1, s[4:0], d}, last_cycle);
         rd(a);
         chk("readback", d, got);
         chk("pio rd", s[4:0], last_cycle[13:8]);
      end
      rd(8'h50);
      chk("reasonlo", 16'h0000, got);
      rd(8'h44);
      chk("cmd read", 16'h00ff, got);
      chk("no pio", 16'h000f, last_cycle[13:8]);
      wr(8'h44, 8'hec);
      chk("cmd pio", 14'h37ec, last_cycle);
      $display("test proxies done");
   end
   endtask
   task t_events;
   begin
      pulse(9'h1ff, 1'h1, 1'h0);
      rd(8'h50);
      chk("reasonlo", 16'h001e, got);
      rd(8'h51);
      chk("reasonhi", 16'h009f, got);
      chk("shortcnt", 16'h0001, short_count_done);
      chk("irq off", 16'h0000, dma_irq);
      wr(8'h55, 8'h01);
      chk("irq on", 16'h0001, dma_irq);
      rd(8'h51);
      chk("masked", 16'h0001, got & 8'h01);
      wr(8'h50, 8'h00);
      rd(8'h50);
      chk("zero wr", 16'h001e, got);
      wr(8'h51, 8'hff);
      rd(8'h51);
      chk("clearhi", 16'h0080, got);
      chk("irq clr", 16'h0000, dma_irq);
      wr(8'h50, 8'hff);
      rd(8'h50);
      chk("clearlo", 16'h0000, got);
      $display("test events done");
   end
   endtask
   task t_modes;
   begin
      pulse(9'h068, 1'h0, 1'h0);
      rd(8'h51);
      chk("no mode", 16'h0084, got);
      chk("shortpre", 16'h0001, short_premature);
      pulse(9'h048, 1'h0, 1'h1);
      rd(8'h51);
      chk("master", 16'h0085, got);
      chk("shortcnt", 16'h0001, short_count_done);
      chk("irq", 16'h0001, dma_irq);
      $display("test modes done");
   end
   endtask
   task t_bus_reset;
   begin
      bus_reset = 1'h1;
      @(posedge clk) #1;
      bus_reset = 1'h0;
      chk("irq", 16'h0000, dma_irq);
      rd(8'h51);
      chk("reasonhi", 16'h0000, got);
      rd(8'h4b);
      chk("proxy", 16'h0000, got);
      $display("test bus reset done");
   end
   endtask
   task tally_and_finish;
   begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      errors = 0;
      n_compared = 0;
      reset = 1'h1;
      bus_reset = 1'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      dma_cmd_done = 1'h0;
      slave_dma_mode = 1'h0;
      master_dma_mode = 1'h0;
      ev_lv = 9'h000;
      repeat (4) @(posedge clk);
      #1 reset = 1'h0;
      t_proxies;
      t_events;
      t_modes;
      t_bus_reset;
      tally_and_finish;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      errors = errors + 1;
      tally_and_finish;
   end
endmodule
